// ==== design/msel_pkg.sv ====
// Constants, register map and types of the multi-speed selector.
// Assumes a 32-bit classic Wishbone slave port and a 100 MHz clock.
package msel_pkg;

    // ========================================================
    // Sizes
    localparam int MSEL_NUM_TERM = 8;
    localparam int MSEL_NUM_SPEED = 16;
    localparam int MSEL_NUM_BIN = 4;
    localparam int MSEL_NUM_LVL = 7;
    localparam int MSEL_ASG_W = 4;
    localparam int MSEL_FREQ_W = 16;
    localparam int MSEL_IDX_W = 4;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] MSEL_OFS_CTRL = 8'h00;
    localparam logic [7:0] MSEL_OFS_BIN_ASG = 8'h04;
    localparam logic [7:0] MSEL_OFS_LVL_ASG = 8'h08;
    localparam logic [7:0] MSEL_OFS_INVERT = 8'h0c;
    localparam logic [7:0] MSEL_OFS_MAX_FREQ = 8'h10;
    localparam logic [7:0] MSEL_OFS_EDIT = 8'h14;
    localparam logic [7:0] MSEL_OFS_STORE = 8'h18;
    localparam logic [7:0] MSEL_OFS_VIEW = 8'h1c;
    localparam logic [7:0] MSEL_OFS_MONITOR = 8'h20;
    localparam logic [7:0] MSEL_OFS_STATUS = 8'h24;
    // Speed table: speed_table_first at 0x40 .. speed_table_last at 0x7c
    localparam logic [7:0] MSEL_OFS_TABLE = 8'h40;
    localparam logic [7:0] MSEL_TABLE_MASK = 8'hc0;

    // ========================================================
    // Field positions
    localparam int MSEL_CTRL_MODE_BIT = 0;
    localparam int MSEL_CTRL_SRC_LO = 1;
    localparam int MSEL_STORE_GO_BIT = 0;
    localparam int MSEL_ST_ACTIVE_BIT = 4;
    localparam int MSEL_ST_RUN_BIT = 5;
    localparam int MSEL_ST_CLAMP_BIT = 6;

    // ========================================================
    // Encodings and reset values
    localparam logic [1:0] MSEL_SRC_TERMINAL = 2'h1;
    localparam logic [1:0] MSEL_SRC_RESET = 2'h1;
    localparam logic [15:0] MSEL_BIN_ASG_RESET = 16'h0000;
    localparam logic [27:0] MSEL_LVL_ASG_RESET = 28'h0000000;
    localparam logic [7:0] MSEL_INVERT_RESET = 8'h00;
    // Maximum frequency in 0.01 Hz units: 50.00 Hz
    localparam logic [15:0] MSEL_MAX_FREQ_RESET = 16'h1388;
    localparam logic [15:0] MSEL_SPEED_RESET = 16'h0000;

    typedef enum logic {
        MSEL_MODE_BINARY,
        MSEL_MODE_BITLEVEL
    } msel_mode_t;

endpackage

// ==== design/msel_sel_if.sv ====
// Carrier between the register side and the speed-select decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface msel_sel_if;
    import msel_pkg::*;
    logic [MSEL_NUM_TERM-1:0] term;
    msel_mode_t mode;
    logic [MSEL_NUM_BIN*MSEL_ASG_W-1:0] bin_asg;
    logic [MSEL_NUM_LVL*MSEL_ASG_W-1:0] lvl_asg;
    logic [MSEL_IDX_W-1:0] index;
    logic active;

    modport dec (input term, mode, bin_asg, lvl_asg, output index, active);
    modport ctl (output term, mode, bin_asg, lvl_asg, input index, active);
endinterface

// ==== design/msel_decoder.sv ====
// Terminal-to-speed-index decoder for both selection modes.
// Assumes terminals arrive already inverted to logical on/off.
`timescale 1ns/1ps
module msel_decoder
    import msel_pkg::*;
(
    msel_sel_if.dec sel
);

    // Assignment field: top bit = function assigned, low bits = terminal
    function automatic logic msel_pick(
        input logic [MSEL_NUM_TERM-1:0] terms,
        input logic [MSEL_ASG_W-1:0] asg
    );
        msel_pick = asg[MSEL_ASG_W-1] ? terms[asg[MSEL_ASG_W-2:0]] : 1'b0;
    endfunction

    // ========================================================
    // Decode
    always_comb begin
        logic [MSEL_IDX_W-1:0] bidx;
        logic [MSEL_IDX_W-1:0] lidx;
        logic lany;
        bidx = '0;
        lidx = '0;
        lany = 1'b0;
        for (int b = 0; b < MSEL_NUM_BIN; b++) begin
            // Unassigned bits drop to zero
            bidx[b] = msel_pick(sel.term,
                sel.bin_asg[b*MSEL_ASG_W +: MSEL_ASG_W]);
        end
        // Walk downward so the lowest active select is left last
        for (int n = MSEL_NUM_LVL; n >= 1; n--) begin
            if (msel_pick(sel.term,
                    sel.lvl_asg[(n-1)*MSEL_ASG_W +: MSEL_ASG_W])) begin
                lidx = MSEL_IDX_W'(n);
                lany = 1'b1;
            end
        end
        // No select on leaves lidx at speed 0
        if (sel.mode == MSEL_MODE_BINARY) begin
            sel.index = bidx;
            sel.active = |bidx;
        end else begin
            sel.index = lidx;
            sel.active = lany;
        end
    end

endmodule // msel_decoder

// ==== design/msel_top.sv ====
// Multi-speed selector: speed table, terminal decode, target output.
// Assumes terminals, run and reference inputs synchronous to clk_i,
// and a classic Wishbone master on the register port.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module msel_top
    import msel_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [MSEL_NUM_TERM-1:0] term_i,
    input wire logic run_i,
    input wire logic [MSEL_FREQ_W-1:0] term_ref_i,
    output logic [MSEL_FREQ_W-1:0] target_freq_o,
    output logic [MSEL_IDX_W-1:0] sel_index_o,
    output logic sel_active_o
);

    // ========================================================
    // State
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        msel_mode_t mode;
        logic [1:0] src;
        logic [MSEL_NUM_BIN*MSEL_ASG_W-1:0] bin_asg;
        logic [MSEL_NUM_LVL*MSEL_ASG_W-1:0] lvl_asg;
        logic [MSEL_NUM_TERM-1:0] inv;
        logic [MSEL_FREQ_W-1:0] max_freq;
        logic [MSEL_FREQ_W-1:0] edit;
        logic [MSEL_NUM_TERM-1:0] term;
        logic [MSEL_IDX_W-1:0] index;
        logic active;
        logic clamp;
        logic [MSEL_FREQ_W-1:0] target;
        logic [MSEL_NUM_SPEED-1:0][MSEL_FREQ_W-1:0] table_v;
    } msel_state_t;

    msel_state_t s_q;
    msel_state_t s_d;

    msel_sel_if sel();

    msel_decoder u_dec (
        .sel(sel)
    );

    assign sel.term = s_q.term;
    assign sel.mode = s_q.mode;
    assign sel.bin_asg = s_q.bin_asg;
    assign sel.lvl_asg = s_q.lvl_asg;

    // ========================================================
    // Helpers

    // Merge a write under byte enables
    function automatic logic [31:0] msel_merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        msel_merge = r;
    endfunction

    // Zero-extend a frequency to a bus word
    function automatic logic [31:0] msel_word(
        input logic [MSEL_FREQ_W-1:0] f
    );
        msel_word = {{(32-MSEL_FREQ_W){1'b0}}, f};
    endfunction

    // ========================================================
    // Next state
    always_comb begin
        logic [31:0] w;
        logic [31:0] rd;
        logic [MSEL_FREQ_W-1:0] pick;
        logic [MSEL_IDX_W-1:0] tix;
        w = '0;
        rd = '0;
        pick = '0;
        tix = wb_adr_i[5:2];
        s_d = s_q;
        s_d.ack = 1'b0;

        // Inversion applied before decode, so on means asserted
        s_d.term = term_i ^ s_q.inv;
        s_d.index = sel.index;
        s_d.active = sel.active;

        // Bus access: answered one cycle after the request appears
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack = 1'b1;
            if (wb_we_i) begin
                if ((wb_adr_i & MSEL_TABLE_MASK) == MSEL_OFS_TABLE) begin
                    // Direct parameter programming of any slot
                    w = msel_merge(msel_word(s_q.table_v[tix]),
                        wb_dat_i, wb_sel_i);
                    s_d.table_v[tix] = w[MSEL_FREQ_W-1:0];
                end else begin
                    unique case (wb_adr_i)
                        MSEL_OFS_CTRL: begin
                            w = msel_merge({29'h0000000, s_q.src,
                                1'(s_q.mode)}, wb_dat_i, wb_sel_i);
                            s_d.mode = msel_mode_t'(w[MSEL_CTRL_MODE_BIT]);
                            s_d.src = w[MSEL_CTRL_SRC_LO +: 2];
                        end
                        MSEL_OFS_BIN_ASG: begin
                            w = msel_merge({16'h0000, s_q.bin_asg},
                                wb_dat_i, wb_sel_i);
                            s_d.bin_asg = w[15:0];
                        end
                        MSEL_OFS_LVL_ASG: begin
                            w = msel_merge({4'h0, s_q.lvl_asg},
                                wb_dat_i, wb_sel_i);
                            s_d.lvl_asg = w[27:0];
                        end
                        MSEL_OFS_INVERT: begin
                            w = msel_merge({24'h000000, s_q.inv},
                                wb_dat_i, wb_sel_i);
                            s_d.inv = w[7:0];
                        end
                        MSEL_OFS_MAX_FREQ: begin
                            w = msel_merge(msel_word(s_q.max_freq),
                                wb_dat_i, wb_sel_i);
                            s_d.max_freq = w[MSEL_FREQ_W-1:0];
                        end
                        MSEL_OFS_EDIT: begin
                            // Editing alone leaves the table untouched
                            w = msel_merge(msel_word(s_q.edit),
                                wb_dat_i, wb_sel_i);
                            s_d.edit = w[MSEL_FREQ_W-1:0];
                        end
                        MSEL_OFS_STORE: begin
                            // Only a stopped drive takes a switch store;
                            // a store while running is dropped silently
                            if (wb_sel_i[0] && wb_dat_i[MSEL_STORE_GO_BIT]
                                    && !run_i) begin
                                s_d.table_v[s_q.index] =
                                    s_q.edit;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end else begin
                if ((wb_adr_i & MSEL_TABLE_MASK) == MSEL_OFS_TABLE) begin
                    rd = msel_word(s_q.table_v[tix]);
                end else begin
                    unique case (wb_adr_i)
                        MSEL_OFS_CTRL:
                            rd = {29'h0000000, s_q.src, 1'(s_q.mode)};
                        MSEL_OFS_BIN_ASG: rd = {16'h0000, s_q.bin_asg};
                        MSEL_OFS_LVL_ASG: rd = {4'h0, s_q.lvl_asg};
                        MSEL_OFS_INVERT: rd = {24'h000000, s_q.inv};
                        MSEL_OFS_MAX_FREQ: rd = msel_word(s_q.max_freq);
                        MSEL_OFS_EDIT: rd = msel_word(s_q.edit);
                        // Entry of the currently selected speed
                        MSEL_OFS_VIEW:
                            rd = msel_word(
                                s_q.table_v[s_q.index]);
                        MSEL_OFS_MONITOR:
                            rd = msel_word(s_q.target);
                        MSEL_OFS_STATUS: begin
                            rd[MSEL_IDX_W-1:0] = s_q.index;
                            rd[MSEL_ST_ACTIVE_BIT] = s_q.active;
                            rd[MSEL_ST_RUN_BIT] = run_i;
                            rd[MSEL_ST_CLAMP_BIT] = s_q.clamp;
                        end
                        default: rd = '0;
                    endcase
                end
            end
        end
        s_d.dat = rd;

        // Target frequency tracks selects every cycle, run or stop, while src is MSEL_SRC_TERMINAL
        if (s_q.src == MSEL_SRC_TERMINAL && s_q.active) begin
            pick = s_q.table_v[s_q.index];
        end else begin
            pick = term_ref_i;
        end
        // Above the maximum the stored speed cannot be reached
        s_d.clamp = pick > s_q.max_freq;
        s_d.target = s_d.clamp ? s_q.max_freq : pick;
        // Three-stage path: term -> index -> target, no stop needed
    end

    // ========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.mode <= MSEL_MODE_BINARY;
            s_q.src <= MSEL_SRC_RESET;
            s_q.bin_asg <= MSEL_BIN_ASG_RESET;
            s_q.lvl_asg <= MSEL_LVL_ASG_RESET;
            s_q.inv <= MSEL_INVERT_RESET;
            s_q.max_freq <= MSEL_MAX_FREQ_RESET;
            for (int i = 0; i < MSEL_NUM_SPEED; i++) begin
                s_q.table_v[i] <= MSEL_SPEED_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Outputs
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;
    assign target_freq_o = s_q.target;
    assign sel_index_o = s_q.index;
    assign sel_active_o = s_q.active;

endmodule // msel_top

// ==== testbench/msel_switch_model.sv ====
// Model of the switches or PLC outputs on the input terminals.
// Assumes the bench sets logical switch states just after a clock edge.
`timescale 1ns/1ps
module msel_switch_model
    import msel_pkg::*;
(
    input wire logic clk_i,
    input wire logic [MSEL_NUM_TERM-1:0] sw_i,
    input wire logic [MSEL_NUM_TERM-1:0] nc_i,
    output logic [MSEL_NUM_TERM-1:0] term_o
);
    // ==========================================================
    // Contacts
    // A closed switch on normally-closed wiring leaves the pin low
    always_ff @(posedge clk_i) begin
        term_o <= sw_i ^ nc_i;
    end
endmodule // msel_switch_model

// ==== testbench/msel_top_assertions.sv ====
// Port-level checks of the multi-speed selector top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module msel_top_assertions
    import msel_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [MSEL_NUM_TERM-1:0] term_i,
    input wire logic run_i,
    input wire logic [MSEL_FREQ_W-1:0] term_ref_i,
    input wire logic [MSEL_FREQ_W-1:0] target_freq_o,
    input wire logic [MSEL_IDX_W-1:0] sel_index_o,
    input wire logic sel_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    assign req = wb_cyc_i & wb_stb_i;

    // ==========================================================
    // Bus
    chk_ack_one_cycle: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    chk_ack_caused: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");

    // ==========================================================
    // Selection
    chk_active_index: assert property (
        sel_active_o == (sel_index_o != 4'h0))
        else $error("active flag disagrees with index");
    chk_index_hold: assert property (
        ($stable(term_i) && !req)[*3] |-> $stable(sel_index_o))
        else $error("index moved without cause");
    chk_target_hold: assert property (
        ($stable(sel_index_o) && !req && $stable(sel_active_o)
        && $stable(term_ref_i))[*3] |-> $stable(target_freq_o))
        else $error("target moved without cause");
    chk_idle_ref: assert property (
        !sel_active_o && $stable(sel_active_o) && $stable(term_ref_i)
        |=> target_freq_o <= $past(term_ref_i))
        else $error("idle target above reference");

    cover property (wb_ack_o && !run_i);
    cover property ($rose(sel_active_o));
    cover property (sel_index_o == 4'hf);
endmodule // msel_top_assertions

bind msel_top msel_top_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .term_i(term_i), .run_i(run_i),
    .term_ref_i(term_ref_i), .target_freq_o(target_freq_o),
    .sel_index_o(sel_index_o), .sel_active_o(sel_active_o));

// ==== testbench/msel_top_tb.sv ====
// Self-checking bench of the multi-speed selector.
// Assumes the switch model and the bound port checker.
`timescale 1ns/1ps
module msel_top_tb;
    import msel_pkg::*;
    localparam logic [15:0] ref_val = 16'h0999;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic run = 1'b0, ack, act;
    logic [7:0] adr = 8'h00, sw = 8'h00, nc = 8'h00, term;
    logic [3:0] sel = 4'hf, idx;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] tgt;
    logic [15:0] tref = ref_val;
    int errors = 0, cmp_count = 0, cycles = 0;

    msel_switch_model u_sw (.clk_i(clk), .sw_i(sw), .nc_i(nc), .term_o(term));
    msel_top uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .term_i(term), .run_i(run),
        .term_ref_i(tref), .target_freq_o(tgt), .sel_index_o(idx),
        .sel_active_o(act));

    always #5 clk = ~clk;

    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb_xfer(input logic w, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Only the bench timeout ends a hung access
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // Terminal to target takes four edges including the switch model
    task automatic put(input logic [7:0] s);
        sw <= s;
        repeat (6) @(posedge clk);
    endtask
    function automatic logic [15:0] ent(input int i);
        return 16'h0100 + 16'(i) * 16'h0011;
    endfunction
    function automatic logic [31:0] exp_t(input int i);
        return {16'h0, (i == 0) ? ref_val : ent(i)};
    endfunction

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        put(8'h00);
        check({16'h0, tgt}, {16'h0, ref_val});
        rd_chk(MSEL_OFS_CTRL, 32'h2);
        rd_chk(MSEL_OFS_MAX_FREQ, 32'h1388);
        sel <= 4'h1;
        wb_wr(MSEL_OFS_MAX_FREQ, 32'h0000ffff);
        sel <= 4'hf;
        rd_chk(MSEL_OFS_MAX_FREQ, 32'h13ff);
        wb_wr(MSEL_OFS_MAX_FREQ, 32'h1388);
        rd_chk(MSEL_OFS_TABLE + 8'h3c, 32'h0);
        wb_wr(8'h30, 32'hffffffff);
        rd_chk(8'h30, 32'h0);
    endtask
    task automatic t_binary;
        logic [7:0] s;
        for (int i = 0; i < 16; i++) begin
            wb_wr(MSEL_OFS_TABLE + 8'(4 * i), {16'h0, ent(i)});
        end
        wb_wr(MSEL_OFS_BIN_ASG, 32'h0000b8fe);
        run <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            s = {i[1], i[0], 2'b00, i[3], 2'b00, i[2]};
            put(s);
            check({28'h0, idx}, 32'(i));
            check({16'h0, tgt}, exp_t(i));
            rd_chk(MSEL_OFS_MONITOR, exp_t(i));
        end
    endtask
    task automatic t_partial;
        wb_wr(MSEL_OFS_BIN_ASG, 32'h000000fe);
        for (int i = 0; i < 4; i++) begin
            put({i[1], i[0], 6'b001001});
            check({28'h0, idx}, 32'(i));
        end
    endtask
    task automatic t_bitlevel;
        wb_wr(MSEL_OFS_CTRL, 32'h3);
        wb_wr(MSEL_OFS_LVL_ASG, 32'h0fedcba9);
        for (int n = 0; n < 8; n++) begin
            put((n == 0) ? 8'h01 : 8'hff << n);
            check({28'h0, idx}, 32'(n));
            check({31'h0, act}, {31'h0, n != 0});
            check({16'h0, tgt}, exp_t(n));
        end
    endtask
    task automatic t_invert;
        wb_wr(MSEL_OFS_INVERT, 32'h4);
        nc <= 8'h04;
        put(8'h04);
        check({28'h0, idx}, 32'h2);
        put(8'h00);
        check({28'h0, idx}, 32'h0);
    endtask
    task automatic t_store;
        run <= 1'b0;
        put(8'h08);
        wb_wr(MSEL_OFS_EDIT, 32'h0777);
        rd_chk(MSEL_OFS_VIEW, {16'h0, ent(3)});
        run <= 1'b1;
        wb_wr(MSEL_OFS_STORE, 32'h1);
        rd_chk(MSEL_OFS_VIEW, {16'h0, ent(3)});
        rd_chk(MSEL_OFS_STATUS, 32'h33);
        run <= 1'b0;
        wb_wr(MSEL_OFS_STORE, 32'h1);
        rd_chk(MSEL_OFS_VIEW, 32'h777);
        rd_chk(MSEL_OFS_TABLE + 8'h0c, 32'h777);
        put(8'h08);
        check({16'h0, tgt}, 32'h777);
        rd_chk(MSEL_OFS_STATUS, 32'h13);
    endtask
    task automatic t_clamp;
        wb_wr(MSEL_OFS_TABLE + 8'h0c, 32'h1770);
        put(8'h08);
        check({16'h0, tgt}, 32'h1388);
        rd_chk(MSEL_OFS_STATUS, 32'h53);
        wb_wr(MSEL_OFS_MAX_FREQ, 32'h1770);
        put(8'h08);
        check({16'h0, tgt}, 32'h1770);
        wb_wr(MSEL_OFS_CTRL, 32'h1);
        put(8'h08);
        check({16'h0, tgt}, {16'h0, ref_val});
        tref <= 16'h0555;
        put(8'h08);
        check({16'h0, tgt}, 32'h0555);
    endtask

    // ==========================================================
    // Sequence and verdict
    task automatic print_verdict;
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_binary;
        t_partial;
        t_bitlevel;
        t_invert;
        t_store;
        t_clamp;
        print_verdict;
    end
endmodule // msel_top_tb
